// File: verilog/hts_consts.svh
`ifndef HTS_CONSTS_SVH
`define HTS_CONSTS_SVH

// ********************************************************
// register byte addresses on the control port
// ********************************************************
`define HTS_RX_CTRL_ADDR   8'hb8
`define HTS_RX_SUPP_ADDR   8'hb9
`define HTS_TX_CTRL_ADDR   8'hba
`define HTS_TX_SUPP_ADDR   8'hbb

// ********************************************************
// register file layout and reset values
// ********************************************************
`define HTS_NUM_REGS       4
`define HTS_IDX_RX_CTRL    0
`define HTS_IDX_RX_SUPP    1
`define HTS_IDX_TX_CTRL    2
`define HTS_IDX_TX_SUPP    3
`define HTS_REG_RESET      8'h00
`define HTS_UNMAPPED_READ  8'h00

// ********************************************************
// frame geometry
// ********************************************************
`define HTS_SA_SLOT        5'h00
`define HTS_SA_FIRST_POS   3'h3
`define HTS_BIT_TOP        3'h7

`endif

// File: verilog/hts_pkg.sv
`default_nettype none

package hts_pkg;

    // control byte over suppress byte; top bit is source (rx) or enable (tx)
    typedef struct packed {
        logic       top;
        logic       sa_or_slot;
        logic       slot_mode;
        logic [4:0] chan;
        logic [7:0] suppress;
    } hts_path_s;

    typedef logic [3:0][7:0] hts_regs_t;

endpackage : hts_pkg

`default_nettype wire

// File: verilog/hts_ctrl_regs.sv
`include "hts_consts.svh"
`default_nettype none

module hts_ctrl_regs (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [7:0]       bus_addr,
    input  wire logic             bus_wr,
    input  wire logic             bus_rd,
    input  wire logic [7:0]       bus_wdata,
    output logic      [7:0]       bus_rdata,
    output hts_pkg::hts_regs_t    regs
);

    localparam hts_pkg::hts_regs_t ADDRS = {`HTS_TX_SUPP_ADDR, `HTS_TX_CTRL_ADDR,
                                            `HTS_RX_SUPP_ADDR, `HTS_RX_CTRL_ADDR};

    hts_pkg::hts_regs_t regs_q;
    hts_pkg::hts_regs_t regs_d;
    logic [7:0]         rdata_q;
    logic [7:0]         rdata_d;

    // ********************************************************
    // storage, one byte per register
    // ********************************************************
    for (genvar i = 0; i < `HTS_NUM_REGS; i++) begin : g_reg
        always_comb begin
            regs_d[i] = regs_q[i];
            if (bus_wr && bus_addr == ADDRS[i]) begin
                regs_d[i] = bus_wdata;
            end
        end

        always_ff @(posedge clock) begin
            if (reset) begin
                regs_q[i] <= `HTS_REG_RESET;
            end else begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    // ********************************************************
    // read port, data held until the next read
    // ********************************************************
    always_comb begin
        rdata_d = rdata_q;
        if (bus_rd) begin
            if (bus_addr == `HTS_RX_CTRL_ADDR) begin
                rdata_d = regs_q[`HTS_IDX_RX_CTRL];
            end else if (bus_addr == `HTS_RX_SUPP_ADDR) begin
                rdata_d = regs_q[`HTS_IDX_RX_SUPP];
            end else if (bus_addr == `HTS_TX_CTRL_ADDR) begin
                rdata_d = regs_q[`HTS_IDX_TX_CTRL];
            end else if (bus_addr == `HTS_TX_SUPP_ADDR) begin
                rdata_d = regs_q[`HTS_IDX_TX_SUPP];
            end else begin
                rdata_d = `HTS_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= `HTS_UNMAPPED_READ;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;
    assign regs      = regs_q;

endmodule : hts_ctrl_regs

`default_nettype wire

// File: verilog/hts_timeslot_select.sv
// Overview of operation
// - tx single mode uses channel from select bits
// - tx block mode uses per-channel block map
// - tx channel number is five-bit binary
// - rx suppress bit set drops that position
// - tx suppress bit set blocks that position
// - rx source picks control-two Sa or register
// - rx Sa select bits map Sa4..Sa8
// - rx single channel or per-channel block map
// - rx channel number is five-bit binary
`include "hts_consts.svh"
`default_nettype none

module hts_timeslot_select (
    input  wire logic        clock,
    input  wire logic        reset,
    // control port
    input  wire logic [7:0]  bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    // outside selections
    input  wire logic [4:0]  rx_control_two_sa,
    input  wire logic [31:0] rx_per_channel_block,
    input  wire logic [31:0] tx_per_channel_block,
    // receive stream
    input  wire logic        rx_bit_strobe,
    input  wire logic [4:0]  rx_slot,
    input  wire logic [2:0]  rx_bitpos,
    input  wire logic        rx_nfas,
    input  wire logic        rx_line_bit,
    output logic             rx_hdlc_valid,
    output logic             rx_hdlc_bit,
    // transmit stream
    input  wire logic        tx_bit_strobe,
    input  wire logic [4:0]  tx_slot,
    input  wire logic [2:0]  tx_bitpos,
    input  wire logic        tx_nfas,
    input  wire logic        tx_line_in,
    input  wire logic        tx_hdlc_data,
    output logic             tx_hdlc_req,
    output logic             tx_line_valid,
    output logic             tx_line_out
);

    hts_pkg::hts_regs_t regs;
    hts_pkg::hts_path_s rx_cfg;
    hts_pkg::hts_path_s tx_cfg;
    logic [2:0]         rx_idx;
    logic [2:0]         tx_idx;
    logic               rx_sa_pos;
    logic               tx_sa_pos;
    logic [4:0]         rx_sa_sel;
    logic               rx_slot_hit;
    logic               tx_slot_hit;
    logic               rx_take;
    logic               tx_take;
    logic               rx_valid_q;
    logic               rx_valid_d;
    logic               rx_bit_q;
    logic               rx_bit_d;
    logic               tx_valid_q;
    logic               tx_valid_d;
    logic               tx_line_q;
    logic               tx_line_d;

    hts_ctrl_regs u_regs (
        .clock     (clock),
        .reset     (reset),
        .bus_addr  (bus_addr),
        .bus_wr    (bus_wr),
        .bus_rd    (bus_rd),
        .bus_wdata (bus_wdata),
        .bus_rdata (bus_rdata),
        .regs      (regs)
    );

    assign rx_cfg = hts_pkg::hts_path_s'({regs[`HTS_IDX_RX_CTRL], regs[`HTS_IDX_RX_SUPP]});
    assign tx_cfg = hts_pkg::hts_path_s'({regs[`HTS_IDX_TX_CTRL], regs[`HTS_IDX_TX_SUPP]});

    // ********************************************************
    // bit selection
    // ********************************************************
    // bitpos 0 is the first bit on the line, the byte msb
    assign rx_idx = `HTS_BIT_TOP - rx_bitpos;
    assign tx_idx = `HTS_BIT_TOP - tx_bitpos;

    // sa bits live in positions 4..8 of slot zero in non-fas frames
    assign rx_sa_pos = rx_slot == `HTS_SA_SLOT && rx_nfas && rx_bitpos >= `HTS_SA_FIRST_POS;
    assign tx_sa_pos = tx_slot == `HTS_SA_SLOT && tx_nfas && tx_bitpos >= `HTS_SA_FIRST_POS;

    // source clear defers the sa choice to the receive control two bits
    assign rx_sa_sel = rx_cfg.top ? rx_cfg.chan : rx_control_two_sa;

    // single channel compares the full five-bit number; block mode indexes the map
    assign rx_slot_hit = rx_cfg.slot_mode ? rx_per_channel_block[rx_slot]
                                          : rx_slot == rx_cfg.chan;
    assign tx_slot_hit = tx_cfg.slot_mode ? tx_per_channel_block[tx_slot]
                                          : tx_slot == tx_cfg.chan;

    always_comb begin
        rx_take = 1'b0;
        if (!rx_cfg.top || !rx_cfg.sa_or_slot) begin
            rx_take = rx_sa_pos && rx_sa_sel[rx_idx];
        end else begin
            rx_take = rx_slot_hit && !rx_cfg.suppress[rx_idx];
        end
    end

    always_comb begin
        tx_take = 1'b0;
        // with the enable clear the sa/ds0 choice has no effect at all
        if (tx_cfg.top) begin
            if (!tx_cfg.sa_or_slot) begin
                tx_take = tx_sa_pos && tx_cfg.chan[tx_idx];
            end else begin
                tx_take = tx_slot_hit && !tx_cfg.suppress[tx_idx];
            end
        end
    end

    // ********************************************************
    // output stage
    // ********************************************************
    // request is combinational so the hdlc side can answer in the same cycle
    assign tx_hdlc_req = tx_bit_strobe && tx_take;

    always_comb begin
        rx_valid_d = rx_bit_strobe && rx_take;
        rx_bit_d   = rx_bit_q;
        tx_valid_d = tx_bit_strobe;
        tx_line_d  = tx_line_q;
        if (rx_bit_strobe && rx_take) begin
            rx_bit_d = rx_line_bit;
        end
        if (tx_bit_strobe) begin
            tx_line_d = tx_hdlc_req ? tx_hdlc_data : tx_line_in;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_valid_q <= 1'b0;
            rx_bit_q   <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_line_q  <= 1'b0;
        end else begin
            rx_valid_q <= rx_valid_d;
            rx_bit_q   <= rx_bit_d;
            tx_valid_q <= tx_valid_d;
            tx_line_q  <= tx_line_d;
        end
    end

    assign rx_hdlc_valid = rx_valid_q;
    assign rx_hdlc_bit   = rx_bit_q;
    assign tx_line_valid = tx_valid_q;
    assign tx_line_out   = tx_line_q;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    tx_single_a: assert property (tx_bit_strobe && tx_cfg.top && tx_cfg.sa_or_slot
        && !tx_cfg.slot_mode && tx_slot != tx_cfg.chan |-> !tx_hdlc_req)
        else $error("tx data outside the single channel");

    tx_block_a: assert property (tx_bit_strobe && tx_cfg.top && tx_cfg.sa_or_slot
        && tx_cfg.slot_mode |-> tx_hdlc_req == (tx_per_channel_block[tx_slot]
        && !tx_cfg.suppress[tx_idx]))
        else $error("tx block map not followed");

    tx_chan_a: assert property (tx_hdlc_req && tx_cfg.sa_or_slot && !tx_cfg.slot_mode
        |-> tx_slot == regs[`HTS_IDX_TX_CTRL][4:0])
        else $error("tx channel number mismatch");

    rx_suppress_a: assert property (rx_bit_strobe && rx_cfg.top && rx_cfg.sa_or_slot
        && rx_cfg.suppress[rx_idx] |=> !rx_hdlc_valid)
        else $error("suppressed rx bit delivered");

    tx_suppress_a: assert property (tx_bit_strobe && tx_cfg.sa_or_slot
        && tx_cfg.suppress[tx_idx] |-> !tx_hdlc_req ##1 tx_line_out == $past(tx_line_in))
        else $error("suppressed tx bit carried hdlc data");

    tx_disable_a: assert property (tx_bit_strobe && !tx_cfg.top
        |-> !tx_hdlc_req ##1 tx_line_valid && tx_line_out == $past(tx_line_in))
        else $error("tx insertion while disabled");

    tx_insert_a: assert property (tx_hdlc_req |=> tx_line_out == $past(tx_hdlc_data))
        else $error("tx hdlc bit not inserted");

    rx_source_a: assert property (rx_bit_strobe && !rx_cfg.top && rx_slot != `HTS_SA_SLOT
        |=> !rx_hdlc_valid)
        else $error("rx ds0 data taken with source clear");

    rx_sa_pick_a: assert property (rx_bit_strobe && rx_sa_pos && !rx_cfg.sa_or_slot
        && rx_cfg.top |=> rx_hdlc_valid == $past(rx_cfg.chan[rx_idx]))
        else $error("rx sa selection wrong");

    rx_single_a: assert property (rx_bit_strobe && rx_cfg.top && rx_cfg.sa_or_slot
        && !rx_cfg.slot_mode && rx_slot != rx_cfg.chan |=> !rx_hdlc_valid)
        else $error("rx data outside the single channel");

    rx_chan_a: assert property (rx_hdlc_valid && $past(rx_cfg.sa_or_slot && rx_cfg.top
        && !rx_cfg.slot_mode) |-> $past(rx_slot) == $past(regs[`HTS_IDX_RX_CTRL][4:0]))
        else $error("rx channel number mismatch");

    rx_ds0_c:   cover property (rx_hdlc_valid && $past(rx_cfg.sa_or_slot));
    rx_sa_c:    cover property (rx_hdlc_valid && $past(rx_sa_pos));
    tx_block_c: cover property (tx_hdlc_req && tx_cfg.slot_mode);
    tx_sa_c:    cover property (tx_hdlc_req && tx_sa_pos);

endmodule : hts_timeslot_select

`default_nettype wire

// File: testbench/hts_host.sv
`default_nettype none

// ****************************************
// host processor on the control port
// ****************************************
module hts_host (
    input  wire logic       clock,
    output logic      [7:0] bus_addr,
    output logic            bus_wr,
    output logic            bus_rd,
    output logic      [7:0] bus_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_addr  = 8'h00;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_wdata = 8'h00;
    end

    // one cycle per call; strobes stay up until the next call replaces them
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        bus_wr    = w;
        bus_rd    = r;
        bus_addr  = a;
        bus_wdata = d;
    endtask : op
endmodule : hts_host

`default_nettype wire

// File: testbench/testbench.sv
`default_nettype none

// ****************************************
// random configuration and stream check
// ****************************************
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock, reset, rd_seen, rx_bit_strobe, rx_nfas, rx_line_bit, rx_hdlc_valid;
    logic        rx_hdlc_bit, tx_bit_strobe, tx_nfas, tx_line_in, tx_hdlc_data, tx_hdlc_req;
    logic        tx_line_valid, tx_line_out, bus_wr, bus_rd;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata;
    logic [4:0]  rx_control_two_sa, rx_slot, tx_slot;
    logic [2:0]  rx_bitpos, tx_bitpos;
    logic [31:0] rx_per_channel_block, tx_per_channel_block;
    logic [7:0]  rg [4];
    logic        rxq [$];
    logic        txq [$];
    logic [7:0]  rdq [$];
    int          error_cnt, n_compared, seed;

    hts_host host (.clock, .bus_addr, .bus_wr, .bus_rd, .bus_wdata);
    hts_timeslot_select dut (.clock, .reset, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
        .bus_rdata, .rx_control_two_sa, .rx_per_channel_block, .tx_per_channel_block,
        .rx_bit_strobe, .rx_slot, .rx_bitpos, .rx_nfas, .rx_line_bit, .rx_hdlc_valid,
        .rx_hdlc_bit, .tx_bit_strobe, .tx_slot, .tx_bitpos, .tx_nfas, .tx_line_in,
        .tx_hdlc_data, .tx_hdlc_req, .tx_line_valid, .tx_line_out);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    function automatic logic pick(logic [7:0] c, logic [7:0] s, logic [4:0] sa,
                                  logic [31:0] blk, logic [4:0] sl, logic [2:0] bp, logic nf);
        // source clear (top bit low) always routes sa bits, whatever the sa/ds0 bit says
        if (!c[7] || !c[6]) return sl == 5'h00 && nf && bp >= 3'h3 && sa[3'h7 - bp];
        return (c[5] ? blk[sl] : sl == c[4:0]) && !s[3'h7 - bp];
    endfunction : pick

    task automatic wr(input int i, input logic [7:0] d);
        host.op(1'b1, 1'b0, 8'hb8 + i[7:0], d);
        if (i < 4) rg[i] = d;
    endtask : wr

    task automatic rd(input int i);
        host.op(1'b0, 1'b1, 8'hb8 + i[7:0], 8'h00);
        rdq.push_back(i < 4 ? rg[i] : 8'h00);
    endtask : rd

    // slots are biased toward slot 0 and the selected channel so both paths get hits
    task automatic step();
        logic [31:0] r;
        logic        e;
        r = $random(seed);
        @(negedge clock);
        rx_bit_strobe = r[0];
        rx_slot = r[2:1] == 2'h0 ? 5'h00 : r[2:1] == 2'h1 ? rg[0][4:0] : r[7:3];
        rx_bitpos = r[10:8];
        rx_nfas = r[11];
        rx_line_bit = r[12];
        e = pick(rg[0], rg[1], rg[0][7] ? rg[0][4:0] : rx_control_two_sa,
                 rx_per_channel_block, rx_slot, rx_bitpos, rx_nfas);
        if (r[0] && e) rxq.push_back(r[12]);
        tx_bit_strobe = r[13];
        tx_slot = r[15:14] == 2'h0 ? 5'h00 : r[15:14] == 2'h1 ? rg[2][4:0] : r[20:16];
        tx_bitpos = r[23:21];
        tx_nfas = r[24];
        tx_line_in = r[25];
        tx_hdlc_data = r[26];
        e = rg[2][7] && pick(rg[2], rg[3], rg[2][4:0], tx_per_channel_block,
                             tx_slot, tx_bitpos, tx_nfas);
        #1;
        chk(tx_hdlc_req, r[13] && e);
        if (r[13]) txq.push_back(e ? r[26] : r[25]);
    endtask : step

    always @(posedge clock) rd_seen <= bus_rd;

    always @(negedge clock) begin
        if (rd_seen === 1'b1) chk(bus_rdata, rdq.size() > 0 ? rdq.pop_front() : 8'hxx);
        if (rx_hdlc_valid === 1'b1) chk(rx_hdlc_bit, rxq.size() > 0 ? rxq.pop_front() : 1'bx);
        if (tx_line_valid === 1'b1) chk(tx_line_out, txq.size() > 0 ? txq.pop_front() : 1'bx);
    end

    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        seed = 7822;
        {rx_bit_strobe, rx_slot, rx_bitpos, rx_nfas, rx_line_bit} = '0;
        {tx_bit_strobe, tx_slot, tx_bitpos, tx_nfas, tx_line_in, tx_hdlc_data} = '0;
        {rx_control_two_sa, rx_per_channel_block, tx_per_channel_block} = '0;
        for (int i = 0; i < 4; i++) rg[i] = 8'h00;
        reset = 1'b1;
        repeat (10) @(negedge clock);
        reset = 1'b0;
        for (int i = 0; i < 5; i++) rd(i);
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 5; i++) wr(i, 8'($random(seed)));
            rx_control_two_sa = $random(seed);
            rx_per_channel_block = $random(seed);
            tx_per_channel_block = $random(seed);
            for (int i = 0; i < 5; i++) rd(i);
            host.op(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (64) step();
            @(negedge clock);
            rx_bit_strobe = 1'b0;
            tx_bit_strobe = 1'b0;
        end
        repeat (3) @(negedge clock);
        chk(8'(rxq.size() + txq.size() + rdq.size()), 8'h00);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
